// *** common/sync_rx_pkg.sv ***
package sync_rx_pkg;

	// ----------------------------------------
	// bus map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_RXDATA = 8'h04;
	localparam logic [7:0] ADDR_SRSTAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_LINE = 8'h14;
	localparam logic [7:0] ADDR_VECTOR = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// pointer values and commands
	// ----------------------------------------
	localparam logic [2:0] PTR_CMD = 3'h0;
	localparam logic [2:0] PTR_MODE = 3'h1;
	localparam logic [2:0] PTR_VEC = 3'h2;
	localparam logic [2:0] PTR_RXCTL = 3'h3;
	localparam logic [2:0] PTR_TXMODEM = 3'h5;
	localparam logic [2:0] PTR_SYNC1 = 3'h6;
	localparam logic [2:0] PTR_SYNC2 = 3'h7;
	localparam int CMD_LSB = 3;
	typedef enum logic [2:0] {
		CMD_NULL = 3'h0,
		CMD_RESET_EXT = 3'h2,
		CMD_CH_RESET = 3'h3,
		CMD_INT_NEXT = 3'h4,
		CMD_ERR_RESET = 3'h6
	} cmd_t;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MODE_EXT_EN = 0;
	localparam int MODE_SAV = 2;
	localparam int MODE_RXINT_LSB = 3;
	localparam logic [1:0] RXINT_OFF = 2'h0;
	localparam logic [1:0] RXINT_FIRST = 2'h1;
	localparam logic [1:0] RXINT_EVERY = 2'h2;
	localparam int RXC_EN = 0;
	localparam int RXC_SLI = 1;
	localparam int RXC_CRC = 3;
	localparam int RXC_HUNT = 4;
	localparam int RXC_AUTO = 5;
	localparam int RXC_LEN_LSB = 6;
	localparam int TXM_CRC16 = 2;
	localparam int TXM_DTR = 7;
	localparam int SRS_OVERRUN = 5;
	localparam int SRS_CRC = 6;
	localparam int IRQ_RX = 0;
	localparam int IRQ_SPECIAL = 1;
	localparam int IRQ_EXT = 2;
	localparam int IRQ_W = 3;
	localparam int VEC_LSB = 1;
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_EXT = 3'h1;
	localparam logic [2:0] CAUSE_RX = 3'h2;
	localparam logic [2:0] CAUSE_SPECIAL = 3'h3;

	// ----------------------------------------
	// character lengths by code
	// ----------------------------------------
	localparam logic [3:0] LEN_CODE0 = 4'h5;
	localparam logic [3:0] LEN_CODE1 = 4'h7;
	localparam logic [3:0] LEN_CODE2 = 4'h6;
	localparam logic [3:0] LEN_CODE3 = 4'h8;
	localparam logic [7:0] RESET_VECTOR = 8'h00;

	typedef enum logic {
		ST_HUNT = 1'b0,
		ST_DATA = 1'b1
	} rx_state_t;

endpackage

// *** src/irq_sticky.sv ***
`timescale 1ns/1ps
module irq_sticky #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// events and clears
	input wire logic [W-1:0] set_in,
	input wire logic [W-1:0] clr_in,
	input wire logic [W-1:0] mask_in,
	// status
	output logic [W-1:0] status,
	output logic irq
);
	generate
		if (W < 1) begin : g_bad
			$error("irq_sticky needs at least one bit");
		end
	endgenerate

	// set wins over a clear in the same cycle
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				status[i] <= 1'b0;
			end else if (set_in[i]) begin
				status[i] <= 1'b1;
			end else if (clr_in[i]) begin
				status[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask_in);
		end
	end
endmodule

// *** src/sync_hunter.sv ***
`timescale 1ns/1ps
module sync_hunter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// serial bits
	input wire logic bit_in,
	input wire logic bit_take,
	// setup
	input wire logic [7:0] sync_one,
	input wire logic [7:0] sync_two,
	input wire logic [1:0] len_code,
	input wire logic hunt_req,
	// characters
	output logic char_valid,
	output logic [7:0] char_data,
	output logic in_hunt
);
	sync_rx_pkg::rx_state_t state_reg;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic [3:0] count_reg;
	logic [3:0] len;

	assign shift_next = {bit_in, shift_reg[15:1]};
	assign in_hunt = (state_reg == sync_rx_pkg::ST_HUNT);

	always_comb begin
		case (len_code)
			2'h0: len = sync_rx_pkg::LEN_CODE0;
			2'h1: len = sync_rx_pkg::LEN_CODE1;
			2'h2: len = sync_rx_pkg::LEN_CODE2;
			default: len = sync_rx_pkg::LEN_CODE3;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg <= 16'h0000;
		end else if (bit_take) begin
			shift_reg <= shift_next;
		end
	end

	// bits arrive first-sent first; two syncs in a row end the hunt
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= sync_rx_pkg::ST_HUNT;
			count_reg <= 4'h0;
			char_valid <= 1'b0;
			char_data <= 8'h00;
		end else begin
			char_valid <= 1'b0;
			if (hunt_req) begin
				state_reg <= sync_rx_pkg::ST_HUNT;
				count_reg <= 4'h0;
			end else if (bit_take) begin
				case (state_reg)
					sync_rx_pkg::ST_HUNT: begin
						if (shift_next == {sync_two, sync_one}) begin
							state_reg <= sync_rx_pkg::ST_DATA;
							count_reg <= 4'h0;
						end
					end
					sync_rx_pkg::ST_DATA: begin
						if (count_reg + 4'h1 == len) begin
							count_reg <= 4'h0;
							char_valid <= 1'b1;
							char_data <= shift_next[15:8] >> (4'h8 - len);
						end else begin
							count_reg <= count_reg + 4'h1;
						end
					end
					default: state_reg <= sync_rx_pkg::ST_HUNT;
				endcase
			end
		end
	end
endmodule

// *** src/sync_rx_channel.sv ***
`timescale 1ns/1ps
module sync_rx_channel #(
	parameter bit SECOND_CHANNEL = 1'b1,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line
	input wire logic rx_bit_in,
	input wire logic rx_bit_strobe,
	input wire logic carrier_detect_in,
	// modem control
	output logic dtr_out,
	output logic crc16_select_out,
	// dma handshake
	output logic dma_ready,
	output logic [7:0] dma_data,
	input wire logic dma_ack,
	// interrupt
	output logic irq_out
);
	generate
		if (ADDR_W < 8) begin : g_bad_addr
			$error("sync_rx_channel needs an address of at least 8 bits");
		end
	endgenerate

	// ----------------------------------------
	// write registers
	// ----------------------------------------
	logic [2:0] command_pointer_reg;
	logic [7:0] interrupt_mode_reg;
	logic [7:0] vector_reg;
	logic [7:0] receive_control_reg;
	logic [7:0] transmit_modem_control_reg;
	logic [7:0] sync_char_one_reg;
	logic [7:0] sync_char_two_reg;
	localparam int IRQ_MASK_W = sync_rx_pkg::IRQ_W;
	logic [IRQ_MASK_W-1:0] irq_mask_reg;

	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic [7:0] wr_byte;
	typedef sync_rx_pkg::cmd_t cmd_field_t;
	cmd_field_t wr_cmd;

	// ----------------------------------------
	// receive path state
	// ----------------------------------------
	logic bit_take;
	logic hunt_req;
	logic char_valid;
	logic [7:0] char_data;
	logic in_hunt;
	logic msg_started_reg;
	logic strip_char;
	logic buf_full_reg;
	logic buf_cpu_reg;
	logic [7:0] buf_data_reg;
	logic first_armed_reg;
	logic overrun_reg;
	logic carrier_prev_reg;
	logic buf_pop;
	logic load_char;
	logic [1:0] rxint_mode;
	logic [sync_rx_pkg::IRQ_W-1:0] irq_set;
	logic [sync_rx_pkg::IRQ_W-1:0] irq_clr;
	logic [sync_rx_pkg::IRQ_W-1:0] irq_status;
	logic irq_level;
	logic [7:0] vector_read;
	logic [2:0] cause;
	logic [31:0] rdata_next;
	logic rresp_err_next;

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_addr = awaddr_reg[7:0];
	assign rd_addr = s_axi_araddr[7:0];
	assign wr_byte = wdata_reg[7:0];
	assign wr_cmd = cmd_field_t'(wr_byte[sync_rx_pkg::CMD_LSB +: 3]);
	assign rxint_mode = interrupt_mode_reg[sync_rx_pkg::MODE_RXINT_LSB +: 2];

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sync_rx_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (wr_addr)
					sync_rx_pkg::ADDR_CMD,
					sync_rx_pkg::ADDR_IRQ_STAT,
					sync_rx_pkg::ADDR_IRQ_MASK: s_axi_bresp <= sync_rx_pkg::RESP_OKAY;
					default: s_axi_bresp <= sync_rx_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pointer-addressed write registers and the directly addressed interrupt mask
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			command_pointer_reg <= sync_rx_pkg::PTR_CMD;
			interrupt_mode_reg <= 8'h00;
			vector_reg <= sync_rx_pkg::RESET_VECTOR;
			receive_control_reg <= 8'h00;
			transmit_modem_control_reg <= 8'h00;
			sync_char_one_reg <= 8'h00;
			sync_char_two_reg <= 8'h00;
			irq_mask_reg <= '0;
		end else if (wr_fire && wstrb_reg[0]) begin
			if (wr_addr == sync_rx_pkg::ADDR_IRQ_MASK) begin
				irq_mask_reg <= wr_byte[IRQ_MASK_W-1:0];
			end else if (wr_addr == sync_rx_pkg::ADDR_CMD) begin
				// any non-command write returns the pointer to the command register
				command_pointer_reg <= sync_rx_pkg::PTR_CMD;
				case (command_pointer_reg)
					sync_rx_pkg::PTR_CMD: begin
						command_pointer_reg <= wr_byte[2:0];
						if (wr_cmd == sync_rx_pkg::CMD_CH_RESET) begin
							interrupt_mode_reg <= 8'h00;
							receive_control_reg <= 8'h00;
							transmit_modem_control_reg <= 8'h00;
						end
					end
					sync_rx_pkg::PTR_MODE: interrupt_mode_reg <= wr_byte;
					sync_rx_pkg::PTR_VEC: vector_reg <= wr_byte;
					sync_rx_pkg::PTR_RXCTL: receive_control_reg <= wr_byte;
					sync_rx_pkg::PTR_TXMODEM: transmit_modem_control_reg <= wr_byte;
					sync_rx_pkg::PTR_SYNC1: sync_char_one_reg <= wr_byte;
					sync_rx_pkg::PTR_SYNC2: sync_char_two_reg <= wr_byte;
					default: command_pointer_reg <= sync_rx_pkg::PTR_CMD;
				endcase
			end
		end
	end

	// ----------------------------------------
	// modem outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dtr_out <= 1'b0;
			crc16_select_out <= 1'b0;
		end else begin
			dtr_out <= transmit_modem_control_reg[sync_rx_pkg::TXM_DTR];
			crc16_select_out <= transmit_modem_control_reg[sync_rx_pkg::TXM_CRC16];
		end
	end

	// ----------------------------------------
	// bit qualification and hunt
	// ----------------------------------------
	assign bit_take = rx_bit_strobe && receive_control_reg[sync_rx_pkg::RXC_EN]
		&& (!receive_control_reg[sync_rx_pkg::RXC_AUTO] || carrier_detect_in);
	assign hunt_req = wr_fire && wstrb_reg[0] && wr_addr == sync_rx_pkg::ADDR_CMD
		&& command_pointer_reg == sync_rx_pkg::PTR_RXCTL && wr_byte[sync_rx_pkg::RXC_HUNT];

	sync_hunter u_hunter (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.bit_in(rx_bit_in),
		.bit_take(bit_take),
		.sync_one(sync_char_one_reg),
		.sync_two(sync_char_two_reg),
		.len_code(receive_control_reg[sync_rx_pkg::RXC_LEN_LSB +: 2]),
		.hunt_req(hunt_req),
		.char_valid(char_valid),
		.char_data(char_data),
		.in_hunt(in_hunt)
	);

	// ----------------------------------------
	// sync stripping and receive buffer
	// ----------------------------------------
	assign strip_char = receive_control_reg[sync_rx_pkg::RXC_SLI] && !msg_started_reg
		&& (char_data == sync_char_one_reg || char_data == sync_char_two_reg);
	assign load_char = char_valid && !strip_char;
	assign buf_pop = (rd_fire && rd_addr == sync_rx_pkg::ADDR_RXDATA)
		|| (dma_ack && dma_ready);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			msg_started_reg <= 1'b0;
		end else if (in_hunt) begin
			msg_started_reg <= 1'b0;
		end else if (load_char) begin
			msg_started_reg <= 1'b1;
		end
	end

	// in first-character mode the first data character goes to the cpu, later ones to the dma side; other modes give every character to the cpu
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_full_reg <= 1'b0;
			buf_cpu_reg <= 1'b0;
			buf_data_reg <= 8'h00;
		end else if (load_char) begin
			buf_full_reg <= 1'b1;
			buf_data_reg <= char_data;
			buf_cpu_reg <= rxint_mode != sync_rx_pkg::RXINT_FIRST || first_armed_reg;
		end else if (buf_pop) begin
			buf_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			first_armed_reg <= 1'b1;
		end else if (load_char && rxint_mode == sync_rx_pkg::RXINT_FIRST) begin
			first_armed_reg <= 1'b0;
		end else if (wr_fire && wr_addr == sync_rx_pkg::ADDR_CMD
			&& command_pointer_reg == sync_rx_pkg::PTR_CMD
			&& wr_cmd == sync_rx_pkg::CMD_INT_NEXT) begin
			first_armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_ready <= 1'b0;
			dma_data <= 8'h00;
		end else begin
			dma_ready <= buf_full_reg && !buf_cpu_reg && !buf_pop && !load_char;
			dma_data <= buf_data_reg;
		end
	end

	// overrun: a character arrives while the buffer is still unread
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			overrun_reg <= 1'b0;
		end else if (load_char && buf_full_reg && !buf_pop) begin
			overrun_reg <= 1'b1;
		end else if (wr_fire && wr_addr == sync_rx_pkg::ADDR_CMD
			&& command_pointer_reg == sync_rx_pkg::PTR_CMD
			&& wr_cmd == sync_rx_pkg::CMD_ERR_RESET) begin
			overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			carrier_prev_reg <= 1'b0;
		end else begin
			carrier_prev_reg <= carrier_detect_in;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb begin
		irq_set = '0;
		irq_set[sync_rx_pkg::IRQ_RX] = load_char && (rxint_mode == sync_rx_pkg::RXINT_EVERY
			|| (rxint_mode == sync_rx_pkg::RXINT_FIRST && first_armed_reg));
		irq_set[sync_rx_pkg::IRQ_SPECIAL] = load_char && buf_full_reg && !buf_pop
			&& rxint_mode != sync_rx_pkg::RXINT_OFF;
		irq_set[sync_rx_pkg::IRQ_EXT] = interrupt_mode_reg[sync_rx_pkg::MODE_EXT_EN]
			&& (carrier_detect_in != carrier_prev_reg);
		irq_clr = '0;
		if (wr_fire && wstrb_reg[0] && wr_addr == sync_rx_pkg::ADDR_IRQ_STAT) begin
			irq_clr = wr_byte[sync_rx_pkg::IRQ_W-1:0];
		end
		if (wr_fire && wr_addr == sync_rx_pkg::ADDR_CMD
			&& command_pointer_reg == sync_rx_pkg::PTR_CMD
			&& wr_cmd == sync_rx_pkg::CMD_RESET_EXT) begin
			irq_clr[sync_rx_pkg::IRQ_EXT] = 1'b1;
		end
	end

	irq_sticky #(
		.W(sync_rx_pkg::IRQ_W)
	) u_irq (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.set_in(irq_set),
		.clr_in(irq_clr),
		.mask_in(irq_mask_reg),
		.status(irq_status),
		.irq(irq_level)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_level;
		end
	end

	// ----------------------------------------
	// vector with cause
	// ----------------------------------------
	always_comb begin
		if (irq_status[sync_rx_pkg::IRQ_SPECIAL]) begin
			cause = sync_rx_pkg::CAUSE_SPECIAL;
		end else if (irq_status[sync_rx_pkg::IRQ_RX]) begin
			cause = sync_rx_pkg::CAUSE_RX;
		end else if (irq_status[sync_rx_pkg::IRQ_EXT]) begin
			cause = sync_rx_pkg::CAUSE_EXT;
		end else begin
			cause = sync_rx_pkg::CAUSE_NONE;
		end
		vector_read = vector_reg;
		if (SECOND_CHANNEL && interrupt_mode_reg[sync_rx_pkg::MODE_SAV]) begin
			vector_read[sync_rx_pkg::VEC_LSB +: 3] = cause;
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	always_comb begin
		rdata_next = 32'h00000000;
		rresp_err_next = 1'b0;
		case (rd_addr)
			sync_rx_pkg::ADDR_CMD: rdata_next[2:0] = command_pointer_reg;
			sync_rx_pkg::ADDR_RXDATA: rdata_next[7:0] = buf_data_reg;
			sync_rx_pkg::ADDR_SRSTAT: rdata_next[sync_rx_pkg::SRS_OVERRUN] = overrun_reg;
			sync_rx_pkg::ADDR_IRQ_STAT: rdata_next[sync_rx_pkg::IRQ_W-1:0] = irq_status;
			sync_rx_pkg::ADDR_IRQ_MASK: rdata_next[sync_rx_pkg::IRQ_W-1:0] = irq_mask_reg;
			sync_rx_pkg::ADDR_LINE: rdata_next[3:0] = {carrier_detect_in, buf_full_reg,
				msg_started_reg, in_hunt};
			sync_rx_pkg::ADDR_VECTOR: rdata_next[7:0] = vector_read;
			default: rresp_err_next = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= sync_rx_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_next;
				s_axi_rresp <= rresp_err_next ? sync_rx_pkg::RESP_SLVERR : sync_rx_pkg::RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** testbench/line_partner.sv ***
`timescale 1ns/1ps
module line_partner #(
	parameter int DMA_WAIT = 3
) (
	// clock
	input wire logic ref_clk,
	// serial line
	output logic rx_bit_in,
	output logic rx_bit_strobe,
	output logic carrier_detect_in,
	// dma side
	input wire logic dma_ready,
	input wire logic [7:0] dma_data,
	output logic dma_ack
);
	logic [7:0] got[$];
	logic [3:0] wt;
	initial begin
		rx_bit_in = 1'b0;
		rx_bit_strobe = 1'b0;
		carrier_detect_in = 1'b0;
		dma_ack = 1'b0;
		wt = 4'h0;
	end
	// dma controller takes each waiting character once, after a delay
	always @(posedge ref_clk) begin
		wt <= (!dma_ready || dma_ack) ? 4'h0 : wt + 4'h1;
		dma_ack <= dma_ready && !dma_ack && (wt >= DMA_WAIT);
		if (dma_ready && dma_ack) got.push_back(dma_data);
	end
	// lsb first; line shows the inverse between strobes
	task automatic send(input logic [7:0] c);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			rx_bit_in <= c[i];
			rx_bit_strobe <= 1'b1;
			@(posedge ref_clk);
			rx_bit_strobe <= 1'b0;
			rx_bit_in <= ~c[i];
			repeat (2) @(posedge ref_clk);
		end
	endtask
	task automatic set_cd(input logic v);
		@(posedge ref_clk);
		carrier_detect_in <= v;
	endtask
endmodule

// *** testbench/sync_rx_asserts.sv ***
`timescale 1ns/1ps
module sync_rx_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// dma and interrupt
	input wire logic dma_ready,
	input wire logic [7:0] dma_data,
	input wire logic dma_ack,
	input wire logic irq_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_reset_clear: assert property ($rose(rst_b) |-> !irq_out && !dma_ready
		##1 s_axi_awready && s_axi_arready) else $error("bad state after reset");
	a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_aw_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	a_ar_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_dma_hold: assert property (dma_ready && !dma_ack |=> dma_ready && $stable(dma_data))
		else $error("dma character lost");
	a_dma_take: assert property (dma_ready && dma_ack |=> !dma_ready)
		else $error("dma ready stuck");
	cover property (dma_ready && dma_ack);
	cover property ($rose(irq_out));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind sync_rx_channel sync_rx_asserts chk_i (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.dma_ready(dma_ready),
	.dma_data(dma_data),
	.dma_ack(dma_ack),
	.irq_out(irq_out)
);

// *** testbench/sync_rx_channel_bench.sv ***
`timescale 1ns/1ps
module sync_rx_channel_bench;
	logic ref_clk, rst_b;
	logic [7:0] s_axi_awaddr, s_axi_araddr, dma_data;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rx_bit_in, rx_bit_strobe, carrier_detect_in, dtr_out, crc16_select_out;
	logic dma_ready, dma_ack, irq_out;
	int failures, checked;
	logic [7:0] msg[7] = '{8'h3c, 8'ha5, 8'h3c, 8'ha5, 8'h5a, 8'hc3, 8'h7e};
	sync_rx_channel uut (.*);
	line_partner p (.*);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ----
	// bus tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata, d);
		chk({30'h0, s_axi_rresp}, {30'h0, e});
	endtask
	task automatic wp(input logic [7:0] c, input logic [7:0] v);
		wr(8'h00, {24'h0, c}, 2'h0);
		wr(8'h00, {24'h0, v}, 2'h0);
	endtask
	task automatic close_out;
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk);
		failures++;
		close_out;
	end
	// ----
	// tests
	// ----
	initial begin
		rst_b = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		failures = 0;
		checked = 0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		wp(8'h15, 8'h84);
		@(posedge ref_clk);
		chk({31'h0, dtr_out}, 32'h1);
		chk({31'h0, crc16_select_out}, 32'h1);
		wp(8'h06, 8'h3c);
		wp(8'h07, 8'ha5);
		wr(8'h10, 32'h7, 2'h0);
		wp(8'h11, 8'h0d);
		wp(8'h23, 8'hf3);
		foreach (msg[i]) p.send(msg[i]);
		rd(8'h0c, 32'h0, 2'h0);
		p.set_cd(1'b1);
		repeat (4) @(posedge ref_clk);
		chk({31'h0, irq_out}, 32'h1);
		rd(8'h0c, 32'h4, 2'h0);
		wr(8'h0c, 32'h4, 2'h0);
		rd(8'h0c, 32'h0, 2'h0);
		wp(8'h23, 8'hf3);
		for (int i = 0; i < 5; i++) p.send(msg[i]);
		rd(8'h0c, 32'h1, 2'h0);
		rd(8'h18, 32'h4, 2'h0);
		rd(8'h04, 32'h5a, 2'h0);
		wr(8'h0c, 32'h1, 2'h0);
		p.send(msg[5]);
		p.send(msg[6]);
		p.send(8'h99);
		repeat (12) @(posedge ref_clk);
		rd(8'h0c, 32'h0, 2'h0);
		chk(p.got.size(), 32'h3);
		chk({24'h0, p.got[0]}, 32'hc3);
		chk({24'h0, p.got[1]}, 32'h7e);
		chk({24'h0, p.got[2]}, 32'h99);
		wp(8'h23, 8'he3);
		p.send(8'h11);
		p.send(8'h22);
		repeat (4) @(posedge ref_clk);
		rd(8'h08, 32'h20, 2'h0);
		rd(8'h0c, 32'h3, 2'h0);
		wr(8'h00, 32'h30, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		wp(8'h01, 8'h15);
		wr(8'h0c, 32'h3, 2'h0);
		p.send(8'h33);
		rd(8'h0c, 32'h1, 2'h0);
		rd(8'h04, 32'h33, 2'h0);
		wr(8'h00, 32'h18, 2'h0);
		@(posedge ref_clk);
		chk({31'h0, dtr_out}, 32'h0);
		wr(8'h40, 32'h0, 2'h2);
		rd(8'h40, 32'h0, 2'h2);
		close_out;
	end
endmodule
